// ==== logic/dssje_exec.v ====
// Behaviour
// - Shift-right-variable decodes on zero major opcode, zero bits 10..6, function 010110.
// - Shift second source right by low six bits of first source, zero fill.
// - Trapping subtract decodes on function 101110; first minus second source.
// - Trapping subtract overflow: no write-back, raise integer overflow.
// - Trapping subtract without overflow writes the full 64-bit difference.
// - Wrapping subtract, function 101111, writes modulo difference, never raises integer overflow.
// - Region jump target: index shifted by two, upper bits from delay-slot address.
// - Every jump takes effect after the one delay-slot instruction.
// - Region jump with link writes PC plus 8 into register 31.
// - Register jump with link decodes on function 001001, bits 20..16 and 10..6 zero.
// - Register jump with link captures target before writing PC plus 8.
// - Misaligned register target faults only when fetched, not at the jump.
// - Jump in last word of a region targets the delay slot's region.
`timescale 1ns/1ps
`default_nettype none
`include "dssje_regs.vh"
module dssje_exec #(
	parameter XLEN = 64
) (
	input wire clk_sys,
	input wire rst_n,
	input wire instr_valid,
	input wire [31:0] instr,
	input wire [XLEN-1:0] pc,
	input wire [XLEN-1:0] src1_val,
	input wire [XLEN-1:0] src2_val,
	input wire mode64_en,
	input wire fetch_valid,
	input wire [XLEN-1:0] fetch_pc,
	output reg wb_en,
	output reg [4:0] wb_reg,
	output reg [XLEN-1:0] wb_data,
	output reg pc_redirect,
	output reg [XLEN-1:0] pc_target,
	output reg exc_overflow,
	output reg exc_reserved,
	output reg exc_addr_fetch
);
	wire is_dword_shift_right_variable;
	wire is_dsubt;
	wire is_dsubw;
	wire is_rjump;
	wire is_rjumpl;
	wire is_rjlink;
	wire [4:0] rd_idx;
	wire [5:0] shamt;
	wire [XLEN-1:0] diff;
	wire ovf;
	wire [XLEN-1:0] slot_pc;
	wire [XLEN-1:0] region_tgt;
	wire [XLEN-1:0] link_val;
	wire is64;
	wire illegal64;
	reg pend_q;
	reg pend_d;
	reg [XLEN-1:0] tgt_q;
	reg [XLEN-1:0] tgt_d;
	reg chk_q;
	reg chk_d;
	reg wb_en_d;
	reg [4:0] wb_reg_d;
	reg [XLEN-1:0] wb_data_d;
	reg pc_redirect_d;
	reg [XLEN-1:0] pc_target_d;
	reg exc_overflow_d;
	reg exc_reserved_d;
	reg exc_addr_fetch_d;

	dssje_decode u_dec (
		.instr(instr),
		.is_dword_shift_right_variable(is_dword_shift_right_variable),
		.is_dsubt(is_dsubt),
		.is_dsubw(is_dsubw),
		.is_rjump(is_rjump),
		.is_rjumpl(is_rjumpl),
		.is_rjlink(is_rjlink)
	);

	// ----------------------------------------
	// Datapath
	// ----------------------------------------
	assign rd_idx = instr[`DSSJE_RD_HI:`DSSJE_RD_LO];
	assign shamt = src1_val[`DSSJE_SHAMT_HI:0];
	assign diff = src1_val - src2_val;
	// Signed overflow: operand signs differ and result sign differs from minuend
	function sub_overflow;
		input [XLEN-1:0] minu;
		input [XLEN-1:0] subt;
		input [XLEN-1:0] res;
		begin
			sub_overflow = (minu[XLEN-1] ^ subt[XLEN-1]) & (minu[XLEN-1] ^ res[XLEN-1]);
		end
	endfunction

	assign ovf = sub_overflow(src1_val, src2_val, diff);
	assign slot_pc = pc + `DSSJE_SLOT_OFS;
	// Upper bits from the delay slot so a last-word jump lands in the next region
	assign region_tgt = {slot_pc[XLEN-1:`DSSJE_REGION_LSB],
		instr[`DSSJE_IDX_HI:0], 2'b00};
	assign link_val = pc + `DSSJE_LINK_OFS;
	assign is64 = is_dword_shift_right_variable | is_dsubt | is_dsubw;
	assign illegal64 = is64 & ~mode64_en;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always @*
	begin
		pend_d = pend_q;
		tgt_d = tgt_q;
		chk_d = chk_q;
		// A fetch ends the watch; a slot retiring in the same cycle starts a new one
		if (fetch_valid & chk_q)
			chk_d = 1'b0;
		if (instr_valid)
		begin
			// Jump issued now is applied after the next (delay-slot) instruction
			pend_d = 1'b0;
			if (pend_q)
				chk_d = 1'b1;
			if (is_rjump | is_rjumpl)
			begin
				pend_d = 1'b1;
				tgt_d = region_tgt;
			end
			else if (is_rjlink)
			begin
				pend_d = 1'b1;
				tgt_d = src1_val;
			end
		end
	end

	// ----------------------------------------
	// Output next values
	// ----------------------------------------
	// Index and data hold between instructions; pulses last one cycle
	always @*
	begin
		wb_en_d = 1'b0;
		wb_reg_d = wb_reg;
		wb_data_d = wb_data;
		exc_overflow_d = 1'b0;
		exc_reserved_d = 1'b0;
		pc_redirect_d = instr_valid & pend_q;
		pc_target_d = pc_target;
		if (instr_valid & pend_q)
			pc_target_d = tgt_q;
		// Fault reported only when the redirected address is fetched
		exc_addr_fetch_d = fetch_valid & chk_q & (fetch_pc == pc_target)
			& (|pc_target[`DSSJE_ALIGN_HI:0]);
		if (instr_valid)
		begin
			wb_reg_d = rd_idx;
			// Reserved check wins so a disabled 64-bit op never writes back
			if (illegal64)
				exc_reserved_d = 1'b1;
			else if (is_dword_shift_right_variable)
			begin
				wb_en_d = 1'b1;
				wb_data_d = src2_val >> shamt;
			end
			else if (is_dsubt)
			begin
				// Data still latches; the register file ignores it without the strobe
				wb_en_d = ~ovf;
				exc_overflow_d = ovf;
				wb_data_d = diff;
			end
			else if (is_dsubw)
			begin
				wb_en_d = 1'b1;
				wb_data_d = diff;
			end
			else if (is_rjumpl)
			begin
				wb_en_d = 1'b1;
				wb_reg_d = `DSSJE_LINK_REG;
				wb_data_d = link_val;
			end
			else if (is_rjlink)
			begin
				wb_en_d = 1'b1;
				wb_data_d = link_val;
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			pend_q <= 1'b0;
			tgt_q <= {XLEN{1'b0}};
			chk_q <= 1'b0;
			wb_en <= 1'b0;
			wb_reg <= 5'h00;
			wb_data <= {XLEN{1'b0}};
			pc_redirect <= 1'b0;
			pc_target <= {XLEN{1'b0}};
			exc_overflow <= 1'b0;
			exc_reserved <= 1'b0;
			exc_addr_fetch <= 1'b0;
		end
		else
		begin
			pend_q <= pend_d;
			tgt_q <= tgt_d;
			chk_q <= chk_d;
			wb_en <= wb_en_d;
			wb_reg <= wb_reg_d;
			wb_data <= wb_data_d;
			pc_redirect <= pc_redirect_d;
			pc_target <= pc_target_d;
			exc_overflow <= exc_overflow_d;
			exc_reserved <= exc_reserved_d;
			exc_addr_fetch <= exc_addr_fetch_d;
		end
	end
endmodule // dssje_exec
`default_nettype wire

// ==== logic/dssje_regs.vh ====
`ifndef DSSJE_REGS_VH
`define DSSJE_REGS_VH
`define DSSJE_OPC_HI 31
`define DSSJE_OPC_LO 26
`define DSSJE_RS_HI 25
`define DSSJE_RS_LO 21
`define DSSJE_RT_HI 20
`define DSSJE_RT_LO 16
`define DSSJE_RD_HI 15
`define DSSJE_RD_LO 11
`define DSSJE_SA_HI 10
`define DSSJE_SA_LO 6
`define DSSJE_FN_HI 5
`define DSSJE_FN_LO 0
`define DSSJE_IDX_HI 25
`define DSSJE_OPC_REGFMT 6'h00
`define DSSJE_OPC_RJUMP 6'h02
`define DSSJE_OPC_RJUMPL 6'h03
`define DSSJE_FN_DWORD_SHIFT_RIGHT_VARIABLE 6'h16
`define DSSJE_FN_DSUBT 6'h2E
`define DSSJE_FN_DSUBW 6'h2F
`define DSSJE_FN_RJLINK 6'h09
`define DSSJE_LINK_REG 5'h1F
`define DSSJE_LINK_OFS 64'h0000000000000008
`define DSSJE_SLOT_OFS 64'h0000000000000004
`define DSSJE_REGION_LSB 28
`define DSSJE_SHAMT_HI 5
`define DSSJE_ALIGN_HI 1
`endif

// ==== logic/dssje_decode.v ====
`timescale 1ns/1ps
`default_nettype none
`include "dssje_regs.vh"
module dssje_decode (
	input wire [31:0] instr,
	output wire is_dword_shift_right_variable,
	output wire is_dsubt,
	output wire is_dsubw,
	output wire is_rjump,
	output wire is_rjumpl,
	output wire is_rjlink
);
	wire [5:0] opc;

	// Register-format match: zero major opcode, zero bits 10..6, given function code
	function regfmt_is;
		input [31:0] word;
		input [5:0] code;
		begin
			regfmt_is = (word[`DSSJE_OPC_HI:`DSSJE_OPC_LO] == `DSSJE_OPC_REGFMT)
				&& ~|word[`DSSJE_SA_HI:`DSSJE_SA_LO]
				&& (word[`DSSJE_FN_HI:`DSSJE_FN_LO] == code);
		end
	endfunction

	assign opc = instr[`DSSJE_OPC_HI:`DSSJE_OPC_LO];
	assign is_dword_shift_right_variable = regfmt_is(instr, `DSSJE_FN_DWORD_SHIFT_RIGHT_VARIABLE);
	assign is_dsubt = regfmt_is(instr, `DSSJE_FN_DSUBT);
	assign is_dsubw = regfmt_is(instr, `DSSJE_FN_DSUBW);
	assign is_rjump = (opc == `DSSJE_OPC_RJUMP);
	assign is_rjumpl = (opc == `DSSJE_OPC_RJUMPL);
	assign is_rjlink = regfmt_is(instr, `DSSJE_FN_RJLINK)
		&& ~|instr[`DSSJE_RT_HI:`DSSJE_RT_LO];
endmodule // dssje_decode
`default_nettype wire

// ==== bench/dssje_exec_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module dssje_exec_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic instr_valid,
	input wire logic mode64_en,
	input wire logic wb_en,
	input wire logic pc_redirect,
	input wire logic exc_overflow,
	input wire logic exc_reserved,
	input wire logic exc_addr_fetch,
	input wire logic [31:0] instr,
	input wire logic [4:0] wb_reg,
	input wire logic [63:0] pc,
	input wire logic [63:0] src1_val,
	input wire logic [63:0] src2_val,
	input wire logic [63:0] wb_data,
	input wire logic [63:0] pc_target
);
default clocking @(posedge clk_sys); endclocking
default disable iff (!rst_n);
wire logic [63:0] d = src1_val - src2_val;
wire logic ov = (src1_val[63] ^ src2_val[63]) & (d[63] ^ src1_val[63]);
wire logic rf = instr_valid && instr[31:26] == 6'h00 && instr[10:6] == 5'h00;
wire logic m = rf && mode64_en;
property p_srl;
	m && instr[5:0] == 6'h16 |=> wb_en && wb_data == ($past(src2_val) >> ($past(src1_val) & 64'h3F));
endproperty
a_srl: assert property (p_srl) else $error("shift");
property p_ovf;
	m && instr[5:0] == 6'h2E && ov |=> exc_overflow && !wb_en;
endproperty
a_ovf: assert property (p_ovf) else $error("overflow");
property p_sub;
	m && instr[5:1] == 5'h17 && !(ov && !instr[0]) |=> wb_en && !exc_overflow && wb_data == $past(d);
endproperty
a_sub: assert property (p_sub) else $error("difference");
property p_res;
	rf && !mode64_en && (instr[5:0] == 6'h16 || instr[5:1] == 5'h17) |=> exc_reserved && !wb_en;
endproperty
a_res: assert property (p_res) else $error("reserved");
property p_jal;
	instr_valid && instr[31:26] == 6'h03 |=> wb_en && wb_reg == 5'h1F && wb_data == $past(pc) + 64'h8;
endproperty
a_jal: assert property (p_jal) else $error("link");
property p_rjl;
	rf && instr[20:16] == 5'h00 && instr[5:0] == 6'h09 |=> wb_en && !exc_addr_fetch;
endproperty
a_rjl: assert property (p_rjl) else $error("register link");
property p_early;
	instr_valid && instr[31:27] == 5'h01 |=> !pc_redirect;
endproperty
a_early: assert property (p_early) else $error("early jump");
property p_tgt;
	instr_valid && instr[31:27] == 5'h01 ##1 instr_valid |=> pc_redirect && pc_target ==
		((($past(pc, 2) + 64'h4) & 64'hFFFFFFFFF0000000) | ({30'h0, $past(instr, 2), 2'h0} & 64'hFFFFFFC));
endproperty
a_tgt: assert property (p_tgt) else $error("target");
endmodule // dssje_exec_chk
bind dssje_exec dssje_exec_chk u_chk (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.instr_valid(instr_valid),
	.mode64_en(mode64_en),
	.wb_en(wb_en),
	.pc_redirect(pc_redirect),
	.exc_overflow(exc_overflow),
	.exc_reserved(exc_reserved),
	.exc_addr_fetch(exc_addr_fetch),
	.instr(instr),
	.wb_reg(wb_reg),
	.pc(pc),
	.src1_val(src1_val),
	.src2_val(src2_val),
	.wb_data(wb_data),
	.pc_target(pc_target)
);
`default_nettype wire

// ==== bench/dssje_fetch_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dssje_fetch_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pc_redirect,
	input wire logic [63:0] pc_target,
	output logic fetch_valid,
	output logic [63:0] fetch_pc
);
// Address toggles between fetches so a stale target never looks fetched
always @(posedge clk_sys)
begin
	fetch_valid <= rst_n & pc_redirect;
	fetch_pc <= pc_redirect ? pc_target : ~fetch_pc;
end
endmodule // dssje_fetch_model
`default_nettype wire

// ==== bench/dssje_exec_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dssje_exec_tb;
logic clk_sys = 1'b0;
logic rst_n = 1'b0;
logic instr_valid = 1'b0;
logic mode64_en = 1'b1;
logic [31:0] instr = 32'h0;
logic [63:0] pc = 64'h0, src1_val = 64'h0, src2_val = 64'h0;
logic fetch_valid, wb_en, pc_redirect, exc_overflow, exc_reserved, exc_addr_fetch;
logic [4:0] wb_reg;
logic [63:0] fetch_pc, wb_data, pc_target;
int fails = 0;
int n_checks = 0;
int cyc = 0;
dssje_exec dut (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.instr_valid(instr_valid),
	.instr(instr),
	.pc(pc),
	.src1_val(src1_val),
	.src2_val(src2_val),
	.mode64_en(mode64_en),
	.fetch_valid(fetch_valid),
	.fetch_pc(fetch_pc),
	.wb_en(wb_en),
	.wb_reg(wb_reg),
	.wb_data(wb_data),
	.pc_redirect(pc_redirect),
	.pc_target(pc_target),
	.exc_overflow(exc_overflow),
	.exc_reserved(exc_reserved),
	.exc_addr_fetch(exc_addr_fetch)
);
dssje_fetch_model u_fm (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.pc_redirect(pc_redirect),
	.pc_target(pc_target),
	.fetch_valid(fetch_valid),
	.fetch_pc(fetch_pc)
);
initial
	forever #4 clk_sys = ~clk_sys;
task finish_test;
	$display("checks %0d mismatches %0d", n_checks, fails);
	if (fails == 0 && n_checks > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
task chk(input string n, input logic [71:0] s, input logic [71:0] e);
	n_checks++;
	if (s !== e)
	begin
		fails++;
		$display("unexpected %s expected %h seen %h", n, e, s);
	end
endtask
// Outputs seen on return belong to the instruction issued by the call before
task iss(input logic [31:0] i, input logic [63:0] p, a, b, input logic v);
	@(posedge clk_sys);
	instr_valid <= v;
	instr <= i;
	pc <= p;
	src1_val <= a;
	src2_val <= b;
	#1;
endtask
task res;
	iss(32'h0, 64'h0, 64'h0, 64'h0, 1'b0);
endtask
// Source 4, destination 3: never equal
function logic [31:0] rf(input logic [5:0] f);
	return {26'h0020060, f};
endfunction
task t_srl;
	iss(rf(6'h16), 64'h0, 64'hFFFFFFFFFFFFFFC0, 64'h8000000000000001, 1'b1);
	iss(rf(6'h16), 64'h0, 64'h7F, 64'h8000000000000001, 1'b1);
	chk("shift0", {wb_en, wb_reg, wb_data}, {6'h23, 64'h8000000000000001});
	res;
	chk("shift63", wb_data, 64'h1);
	$display("done shift");
endtask
task t_sub;
	iss(rf(6'h2E), 64'h0, 64'h5, 64'h7, 1'b1);
	iss(rf(6'h2E), 64'h0, 64'h8000000000000000, 64'h1, 1'b1);
	chk("diff", {wb_en, exc_overflow, wb_data}, {2'b10, 64'hFFFFFFFFFFFFFFFE});
	iss(rf(6'h2F), 64'h0, 64'h8000000000000000, 64'h1, 1'b1);
	chk("trap", {wb_en, exc_overflow}, 2'b01);
	res;
	chk("wrap", {wb_en, exc_overflow, wb_data}, {2'b10, 64'h7FFFFFFFFFFFFFFF});
	$display("done subtract");
endtask
task t_res;
	@(posedge clk_sys);
	mode64_en <= 1'b0;
	iss(rf(6'h16), 64'h0, 64'h1, 64'h2, 1'b1);
	iss(rf(6'h2E), 64'h0, 64'h8000000000000000, 64'h1, 1'b1);
	chk("res_shift", {wb_en, exc_reserved}, 2'b01);
	res;
	chk("res_sub", {wb_en, exc_reserved, exc_overflow}, 3'b010);
	@(posedge clk_sys);
	mode64_en <= 1'b1;
	$display("done reserved");
endtask
task t_jmp(input logic [31:0] i, input logic [63:0] p, t, input logic lk);
	iss(i, p, 64'h0, 64'h0, 1'b1);
	iss(32'h0, p + 64'h4, 64'h0, 64'h0, 1'b1);
	chk("link", {wb_en, pc_redirect}, {lk, 1'b0});
	if (lk)
		chk("link_data", {wb_reg, wb_data}, {5'h1F, p + 64'h8});
	res;
	chk("target", {pc_redirect, pc_target}, {1'b1, t});
	$display("done jump");
endtask
task t_register_jump_link;
	iss(rf(6'h09), 64'h1000, 64'h400002, 64'h0, 1'b1);
	iss(32'h0, 64'h1004, 64'h0, 64'h0, 1'b1);
	chk("rlink", {exc_addr_fetch, wb_en, wb_reg, wb_data}, {2'b01, 5'h03, 64'h1008});
	res;
	chk("rtarget", {pc_redirect, pc_target}, {1'b1, 64'h400002});
	res;
	chk("afetch_early", exc_addr_fetch, 1'b0);
	res;
	chk("afetch", exc_addr_fetch, 1'b1);
	res;
	chk("afetch_once", exc_addr_fetch, 1'b0);
	$display("done register jump");
endtask
always @(posedge clk_sys)
begin
	cyc <= cyc + 1;
	if (cyc == 2000)
	begin
		fails = fails + 1;
		finish_test();
	end
end
initial
begin
	repeat (6) @(posedge clk_sys);
	rst_n <= 1'b1;
	t_srl();
	t_sub();
	t_res();
	t_jmp({6'h02, 26'h0000123}, 64'h0FFFFFFC, 64'h1000048C, 1'b0);
	t_jmp({6'h03, 26'h3FFFFFF}, 64'h120000010, 64'h12FFFFFFC, 1'b1);
	t_register_jump_link();
	finish_test();
end
endmodule // dssje_exec_tb
`default_nettype wire
